// [hdl/tmo_pkg.sv]
// package: register map, fields and carriers of the timer output and prescaler stage
// ======================================================================
package tmo_pkg;
   // ===================================================================
   // register map
   localparam logic [15:0] TMO_PRESCALER_EDGE_SELECT_IDX = 16'hffbb;
   localparam logic [15:0] TMO_TIMER_OUTPUT_CONTROL_IDX = 16'hffbd;
   localparam logic [15:0] TMO_RUN_CONTROL_IDX = 16'hffc0;
   localparam logic [15:0] TMO_STATUS_IDX = 16'hffc1;
   localparam logic [7:0] TMO_TOC_RESET = 8'h00;
   localparam logic [7:0] TMO_PRM_RESET = 8'h00;
   localparam logic [7:0] TMO_TOC_WMASK = 8'h7f;
   localparam logic [7:0] TMO_TOC_RMASK = 8'h33;
   localparam logic [7:0] TMO_PRM_WMASK = 8'hf3;
   // ===================================================================
   // field positions
   localparam int TMO_OUTPUT_ENABLE = 0;
   localparam int TMO_MATCH0_TOGGLE_EN = 1;
   localparam int TMO_LEVEL_CLEAR_TRIG = 2;
   localparam int TMO_LEVEL_SET_TRIG = 3;
   localparam int TMO_MATCH1_TOGGLE_EN = 4;
   localparam int TMO_ONESHOT_MODE = 5;
   localparam int TMO_ONESHOT_SW_TRIGGER = 6;
   // ===================================================================
   // prescaler
   localparam int TMO_DIV4 = 4;
   localparam int TMO_DIV256 = 256;
   localparam logic [1:0] TMO_CLK_DIV1 = 2'h0;
   localparam logic [1:0] TMO_CLK_DIV4 = 2'h1;
   localparam logic [1:0] TMO_CLK_DIV256 = 2'h2;
   localparam logic [1:0] TMO_CLK_EXT = 2'h3;
   localparam logic [1:0] TMO_EDGE_FALL = 2'h0;
   localparam logic [1:0] TMO_EDGE_RISE = 2'h1;
   localparam logic [1:0] TMO_EDGE_BOTH = 2'h3;
   localparam logic [1:0] TMO_OP_STOP = 2'h0;
   localparam logic [1:0] TMO_RESP_OKAY = 2'h0;
   localparam logic [1:0] TMO_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic oneshot_mode;
      logic match1_toggle_en;
      logic match0_toggle_en;
      logic output_enable;
   } tmo_toc_t;

   typedef struct packed {
      logic [1:0] in1_edge;
      logic [1:0] in0_edge;
      logic [1:0] clk_sel;
   } tmo_prm_t;
endpackage

// [hdl/tmo_edge_det.sv]
// module: synchronised edge detector for one external timer input
`timescale 1ns/1ps
module tmo_edge_det
   import tmo_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   input wire logic [1:0] edge_sel,
   input wire logic running,
   input wire logic first_run,
   output logic valid_edge
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic run_q;
   logic rise;
   logic fall;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
      end
   end

   // previous level; on first start a high level counts as rising
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         run_q <= running;
         if (running && !run_q && first_run) begin
            prev_q <= 1'b0;
         end else begin
            prev_q <= sync_q;
         end
      end
   end

   assign rise = sync_q && !prev_q && run_q;
   assign fall = !sync_q && prev_q && run_q;

   always_comb begin
      case (edge_sel)
         TMO_EDGE_FALL: valid_edge = fall;
         TMO_EDGE_RISE: valid_edge = rise;
         TMO_EDGE_BOTH: valid_edge = rise | fall;
         default: valid_edge = 1'b0;
      endcase
   end
endmodule // tmo_edge_det

// [hdl/tmo_prescaler.sv]
// module: count clock enable selection
`timescale 1ns/1ps
module tmo_prescaler
   import tmo_pkg::*;
#(
   parameter int DIV_A = TMO_DIV4,
   parameter int DIV_B = TMO_DIV256
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic running,
   input wire logic [1:0] clk_sel,
   input wire logic ext_edge,
   output logic count_en
);
   localparam int W = $clog2(DIV_B);
   logic [W-1:0] div_q;

   // elaboration check of the divider pair
   if (DIV_A < 2 || DIV_B <= DIV_A || (DIV_B % DIV_A) != 0) begin : g_bad_div
      $error("tmo_prescaler: bad divider values");
   end

   // divider held in reset while stopped
   always_ff @(posedge aclk) begin
      if (!aresetn || !running) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + W'(1);
      end
   end

   always_comb begin
      case (clk_sel)
         TMO_CLK_DIV1: count_en = running;
         TMO_CLK_DIV4: count_en = running && (div_q % W'(DIV_A)) == W'(DIV_A - 1);
         TMO_CLK_DIV256: count_en = running && div_q == W'(DIV_B - 1);
         TMO_CLK_EXT: count_en = running && ext_edge;
         default: count_en = 1'b0;
      endcase
   end
endmodule // tmo_prescaler

// [hdl/tmo_output_ctrl.sv]
// module: timer output control and prescaler stage with AXI4-Lite registers
`timescale 1ns/1ps
module tmo_output_ctrl
   import tmo_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // ===================================================================
   // AXI4-Lite slave
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // ===================================================================
   // counter core side
   input wire logic match0_irq,
   input wire logic match1_irq,
   output logic [1:0] op_enable,
   output logic count_en_q,
   output logic counter_restart_q,
   output logic ext_edge0_q,
   output logic ext_edge1_q,
   // ===================================================================
   // pins
   input wire logic ext_input0,
   input wire logic shared_pin_in,
   input wire logic shared_pin_direction,
   input wire logic shared_port_latch,
   output logic timer_out_pin,
   output logic shared_pin_out,
   output logic shared_pin_oe
);
   typedef enum logic [1:0] {
      TMO_B_IDLE = 2'b00,
      TMO_B_RESP = 2'b01
   } tmo_bus_t;

   tmo_toc_t toc_q;
   tmo_prm_t prm_q;
   logic [1:0] op_q;
   logic first_run_q;
   logic timer_out_q;
   logic running;
   logic ext0_edge;
   logic ext1_edge;
   logic count_en;
   tmo_bus_t wr_q;
   logic aw_have_q;
   logic w_have_q;
   logic [17:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   logic [15:0] widx;
   logic [15:0] ridx;
   logic [7:0] wbyte;
   logic lvl_set;
   logic lvl_clr;
   logic sw_trig;
   logic bad_wr;

   assign running = op_q != TMO_OP_STOP;

   // ===================================================================
   // edge detection and prescaler
   tmo_edge_det u_edge0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_input0),
      .edge_sel(prm_q.in0_edge),
      .running(running),
      .first_run(first_run_q),
      .valid_edge(ext0_edge)
   );

   tmo_edge_det u_edge1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(shared_pin_in),
      .edge_sel(prm_q.in1_edge),
      .running(running),
      .first_run(first_run_q),
      .valid_edge(ext1_edge)
   );

   tmo_prescaler #(
      .DIV_A(TMO_DIV4),
      .DIV_B(TMO_DIV256)
   ) u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .running(running),
      .clk_sel(prm_q.clk_sel),
      .ext_edge(ext0_edge),
      .count_en(count_en)
   );

   // ===================================================================
   // write channel
   assign wr_go = aw_have_q && w_have_q && wr_q == TMO_B_IDLE;
   assign widx = awaddr_q[17:2];
   assign wbyte = wdata_q[7:0];
   assign bad_wr = widx != TMO_PRESCALER_EDGE_SELECT_IDX
      && widx != TMO_TIMER_OUTPUT_CONTROL_IDX && widx != TMO_RUN_CONTROL_IDX;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_q <= TMO_B_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= TMO_RESP_OKAY;
      end else begin
         case (wr_q)
            TMO_B_IDLE: begin
               if (wr_go) begin
                  wr_q <= TMO_B_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= bad_wr ? TMO_RESP_SLVERR : TMO_RESP_OKAY;
               end
            end
            TMO_B_RESP: begin
               if (s_axi_bready) begin
                  wr_q <= TMO_B_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: wr_q <= TMO_B_IDLE;
         endcase
      end
   end

   // ===================================================================
   // registers
   assign sw_trig = wr_go && wstrb_q[0] && widx == TMO_TIMER_OUTPUT_CONTROL_IDX;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         toc_q <= tmo_toc_t'({TMO_TOC_RESET[TMO_ONESHOT_MODE],
                              TMO_TOC_RESET[TMO_MATCH1_TOGGLE_EN],
                              TMO_TOC_RESET[TMO_MATCH0_TOGGLE_EN],
                              TMO_TOC_RESET[TMO_OUTPUT_ENABLE]});
      end else if (sw_trig) begin
         if (!running) begin
            toc_q.oneshot_mode <= wbyte[TMO_ONESHOT_MODE];
            toc_q.match0_toggle_en <= wbyte[TMO_MATCH0_TOGGLE_EN];
            toc_q.output_enable <= wbyte[TMO_OUTPUT_ENABLE];
         end
         toc_q.match1_toggle_en <= wbyte[TMO_MATCH1_TOGGLE_EN];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prm_q <= tmo_prm_t'(TMO_PRM_RESET[7:2]);
      end else if (wr_go && wstrb_q[0] && widx == TMO_PRESCALER_EDGE_SELECT_IDX
                   && !running) begin
         prm_q <= tmo_prm_t'({wbyte[7:4], wbyte[1:0]});
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_q <= TMO_OP_STOP;
      end else if (wr_go && wstrb_q[0] && widx == TMO_RUN_CONTROL_IDX) begin
         op_q <= wbyte[1:0];
      end
   end

   // first start after reset remembered for the input edge detectors
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_run_q <= 1'b1;
      end else if (running) begin
         first_run_q <= 1'b0;
      end
   end

   // ===================================================================
   // trigger bits act once and are never stored
   assign lvl_set = sw_trig && wbyte[TMO_LEVEL_SET_TRIG] && !wbyte[TMO_LEVEL_CLEAR_TRIG];
   assign lvl_clr = sw_trig && wbyte[TMO_LEVEL_CLEAR_TRIG] && !wbyte[TMO_LEVEL_SET_TRIG];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_restart_q <= 1'b0;
      end else begin
         counter_restart_q <= sw_trig && wbyte[TMO_ONESHOT_SW_TRIGGER] && running;
      end
   end

   // ===================================================================
   // timer output flip-flop
   always_ff @(posedge aclk) begin
      if (!aresetn || !toc_q.output_enable) begin
         timer_out_q <= 1'b0;
      end else if (lvl_set) begin
         timer_out_q <= 1'b1;
      end else if (lvl_clr) begin
         timer_out_q <= 1'b0;
      end else if ((match0_irq && toc_q.match0_toggle_en)
                   ^ (match1_irq && toc_q.match1_toggle_en)) begin
         timer_out_q <= !timer_out_q;
      end
   end

   // ===================================================================
   // pin and core outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_out_pin <= 1'b0;
         shared_pin_out <= 1'b0;
         shared_pin_oe <= 1'b0;
         count_en_q <= 1'b0;
         ext_edge0_q <= 1'b0;
         ext_edge1_q <= 1'b0;
         op_enable <= TMO_OP_STOP;
      end else begin
         timer_out_pin <= timer_out_q;
         shared_pin_out <= timer_out_q | shared_port_latch;
         shared_pin_oe <= !shared_pin_direction;
         count_en_q <= count_en;
         ext_edge0_q <= ext0_edge;
         ext_edge1_q <= ext1_edge;
         op_enable <= op_q;
      end
   end

   // ===================================================================
   // read channel
   assign ridx = s_axi_araddr[17:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= TMO_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= TMO_RESP_OKAY;
         case (ridx)
            TMO_TIMER_OUTPUT_CONTROL_IDX: begin
               s_axi_rdata <= {24'h0, 2'h0, toc_q.oneshot_mode, toc_q.match1_toggle_en,
                  2'h0, toc_q.match0_toggle_en, toc_q.output_enable};
            end
            TMO_PRESCALER_EDGE_SELECT_IDX: begin
               s_axi_rdata <= {24'h0, prm_q.in1_edge, prm_q.in0_edge, 2'h0, prm_q.clk_sel};
            end
            TMO_RUN_CONTROL_IDX: s_axi_rdata <= {30'h0, op_q};
            TMO_STATUS_IDX: s_axi_rdata <= {29'h0, first_run_q, running, timer_out_q};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= TMO_RESP_SLVERR;
            end
         endcase
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule // tmo_output_ctrl

// [test/tmo_output_ctrl_assertions.sv]
// checker: port assertions of the timer output stage
`timescale 1ns/1ps
module tmo_output_ctrl_chk
   import tmo_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic match0_irq,
   input wire logic match1_irq,
   input wire logic [1:0] op_enable,
   input wire logic count_en_q,
   input wire logic counter_restart_q,
   input wire logic timer_out_pin,
   input wire logic shared_pin_direction,
   input wire logic shared_pin_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] quiet_q;
   // ===================================================================
   // cycles since the last cause of an output change
   always_ff @(posedge aclk) begin
      if (!aresetn || match0_irq || match1_irq || (s_axi_wvalid && s_axi_wready)) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hf) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end
   // ===================================================================
   // properties
   chk_bresp_timing: assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_awvalid && s_axi_awready, 2) || $past(s_axi_wvalid && s_axi_wready, 2))
      else $error("write response out of step");
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   chk_rvalid_timing: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   chk_restart_pulse: assert property (counter_restart_q |=> !counter_restart_q)
      else $error("restart longer than one cycle");
   chk_stop_gates_count: assert property (op_enable == TMO_OP_STOP [*3] |-> !count_en_q)
      else $error("count enable while stopped");
   chk_oe_follows_dir: assert property ($past(aresetn) |->
      shared_pin_oe == !$past(shared_pin_direction))
      else $error("pin enable not from direction");
   chk_out_has_cause: assert property ($changed(timer_out_pin) |-> quiet_q < 4'h8)
      else $error("timer output moved without cause");
   chk_reset_clears: assert property (disable iff (1'b0) !aresetn |=>
      !s_axi_bvalid && !s_axi_rvalid && !timer_out_pin && op_enable == TMO_OP_STOP)
      else $error("outputs not cleared by reset");
   cov_restart: cover property (counter_restart_q);
   cov_out_rise: cover property ($rose(timer_out_pin));
   cov_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // tmo_output_ctrl_chk

bind tmo_output_ctrl tmo_output_ctrl_chk u_chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .match0_irq, .match1_irq, .op_enable, .count_en_q, .counter_restart_q,
   .timer_out_pin, .shared_pin_direction, .shared_pin_oe
);

// [test/tmo_core_model.sv]
// partner: counter core model raising the compare matches
`timescale 1ns/1ps
module tmo_core_model
   import tmo_pkg::*;
#(
   parameter logic [7:0] CMP0 = 8'h07,
   parameter logic [7:0] CMP1 = 8'h03
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] op_enable,
   input wire logic count_en_q,
   input wire logic counter_restart_q,
   output logic match0_irq,
   output logic match1_irq
);
   logic [7:0] cnt_q;
   logic run;
   assign run = op_enable != TMO_OP_STOP;
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || counter_restart_q) begin
         cnt_q <= 8'h00;
      end else if (count_en_q) begin
         cnt_q <= (cnt_q == CMP0) ? 8'h00 : cnt_q + 8'h01;
      end
   end
   // matches raised whatever the toggle enables
   assign match0_irq = run && count_en_q && cnt_q == CMP0;
   assign match1_irq = run && count_en_q && cnt_q == CMP1;
endmodule // tmo_core_model

// [test/tb_timer_output_and_prescaler_ctrl.sv]
// testbench: register, pin and run checks of the timer output stage
`timescale 1ns/1ps
module tb_timer_output_and_prescaler_ctrl
   import tmo_pkg::*;
;
   localparam logic [17:0] A_PRM = {TMO_PRESCALER_EDGE_SELECT_IDX, 2'b00};
   localparam logic [17:0] A_TOC = {TMO_TIMER_OUTPUT_CONTROL_IDX, 2'b00};
   localparam logic [17:0] A_RUN = {TMO_RUN_CONTROL_IDX, 2'b00};
   localparam logic [17:0] A_STA = {TMO_STATUS_IDX, 2'b00};
   localparam logic [17:0] A_BAD = 18'h00010;
   localparam logic [1:0] OK = TMO_RESP_OKAY;
   logic aclk, aresetn, cnt_on;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, r;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, op_enable;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, match0_irq, match1_irq;
   logic count_en_q, counter_restart_q, ext_edge0_q, ext_edge1_q, ext_input0, shared_pin_in;
   logic shared_pin_direction, shared_port_latch, timer_out_pin, shared_pin_out, shared_pin_oe;
   logic [33:0] expq[$];
   int n_mismatch, num_checks, n_ce, n_e0, n_e1, n_rs, ntog;
   logic [1:0] emode [3] = '{TMO_EDGE_RISE, TMO_EDGE_FALL, TMO_EDGE_BOTH};
   int eexp [3] = '{5, 4, 8};
   int divs [3] = '{1, TMO_DIV4, TMO_DIV256};
   logic [7:0] tv [9] = '{8'h12, 8'h13, 8'h1b, 8'h13, 8'h17, 8'h1b, 8'h1f, 8'h12, 8'h13};
   logic pv [9] = '{0, 0, 1, 1, 0, 1, 1, 0, 0};
   tmo_output_ctrl dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .match0_irq, .match1_irq, .op_enable, .count_en_q, .counter_restart_q,
      .ext_edge0_q, .ext_edge1_q, .ext_input0, .shared_pin_in, .shared_pin_direction,
      .shared_port_latch, .timer_out_pin, .shared_pin_out, .shared_pin_oe
   );
   tmo_core_model u_core (
      .aclk, .aresetn, .op_enable, .count_en_q, .counter_restart_q, .match0_irq, .match1_irq
   );
   // ===================================================================
   // clock, counters and result monitor
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (cnt_on === 1'b1) begin
         n_ce += count_en_q;
         n_e0 += ext_edge0_q;
         n_e1 += ext_edge1_q;
         n_rs += counter_restart_q;
         ntog += match0_irq + match1_irq;
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         chk({s_axi_bresp, 32'h0}, expq.pop_front());
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
      end
   end
   // ===================================================================
   // tasks
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] rs);
      bit da;
      bit dw;
      expq.push_back({rs, 32'h0});
      da = 0;
      dw = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) da = 1;
         if (s_axi_wready === 1'b1) dw = 1;
         if (da) s_axi_awvalid <= 1'b0;
         if (dw) s_axi_wvalid <= 1'b0;
      end while (!(da && dw));
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] d, input logic [1:0] rs);
      expq.push_back({rs, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask
   task automatic pin(input logic e);
      logic [1:0] exp_pin;
      shared_port_latch <= 1'($urandom_range(1));
      shared_pin_direction <= 1'($urandom_range(1));
      repeat (3) @(posedge aclk);
      exp_pin = {e | shared_port_latch, !shared_pin_direction};
      chk({33'h0, timer_out_pin}, {33'h0, e});
      chk({32'h0, shared_pin_out, shared_pin_oe}, {32'h0, exp_pin});
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge aclk);
      n_mismatch++;
      $display("[FAIL] %0t watchdog %h %h", $time, num_checks, n_mismatch);
      wrap_up();
   end
   // ===================================================================
   // main sequence
   initial begin
      void'($urandom(43));
      {aresetn, cnt_on, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
      {ext_input0, shared_pin_in, shared_port_latch} = 3'b110;
      shared_pin_direction = 1'($urandom_range(1));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_TOC, 32'h0, OK);
      rd(A_PRM, 32'h0, OK);
      rd(A_STA, 32'h4, OK);
      wr(A_BAD, 32'h5a, TMO_RESP_SLVERR);
      rd(A_BAD, 32'h0, TMO_RESP_SLVERR);
      foreach (emode[i]) begin
         wr(A_PRM, {24'h0, emode[i], emode[i], 2'b00, TMO_CLK_EXT}, OK);
         {n_ce, n_e0, n_e1} = '0;
         cnt_on <= 1'b1;
         wr(A_RUN, 32'h1, OK);
         repeat (8) begin
            repeat (6 + $urandom_range(7)) @(posedge aclk);
            {ext_input0, shared_pin_in} <= ~{ext_input0, shared_pin_in};
            shared_pin_direction <= 1'b1;
         end
         repeat (8) @(posedge aclk);
         cnt_on <= 1'b0;
         wr(A_RUN, 32'h0, OK);
         chk(34'(n_e0), 34'(eexp[i]));
         chk(34'(n_e1), 34'(eexp[i]));
         chk(34'(n_ce), 34'(eexp[i]));
      end
      for (int s = 0; s < 3; s++) begin
         wr(A_PRM, 32'(s), OK);
         n_ce = 0;
         wr(A_RUN, 32'h1, OK);
         cnt_on <= 1'b1;
         repeat (512) @(posedge aclk);
         cnt_on <= 1'b0;
         wr(A_RUN, 32'h0, OK);
         chk({33'h0, n_ce >= 512 / divs[s] - 1 && n_ce <= 512 / divs[s] + 1}, 34'h1);
      end
      repeat (4) begin
         r = $urandom;
         wr(A_PRM, r, OK);
         rd(A_PRM, r & 32'hf3, OK);
      end
      foreach (tv[i]) begin
         wr(A_TOC, {24'h0, tv[i]}, OK);
         rd(A_TOC, {24'h0, tv[i] & 8'h33}, OK);
         pin(pv[i]);
      end
      wr(A_PRM, {30'h0, TMO_CLK_DIV4}, OK);
      ntog = 0;
      cnt_on <= 1'b1;
      wr(A_RUN, 32'h1, OK);
      repeat (600) @(posedge aclk);
      wr(A_RUN, 32'h0, OK);
      repeat (4) @(posedge aclk);
      cnt_on <= 1'b0;
      chk({33'h0, timer_out_pin}, {33'h0, ntog[0]});
      wr(A_TOC, 32'h33, OK);
      wr(A_RUN, 32'h1, OK);
      n_rs = 0;
      cnt_on <= 1'b1;
      wr(A_TOC, 32'h73, OK);
      rd(A_TOC, 32'h33, OK);
      chk({32'h0, op_enable}, 34'h1);
      rd(A_RUN, 32'h1, OK);
      wr(A_TOC, 32'h20, OK);
      rd(A_TOC, 32'h23, OK);
      wr(A_PRM, 32'h12, OK);
      rd(A_PRM, {30'h0, TMO_CLK_DIV4}, OK);
      cnt_on <= 1'b0;
      wr(A_RUN, 32'h0, OK);
      chk(34'(n_rs), 34'h1);
      wrap_up();
   end
endmodule // tb_timer_output_and_prescaler_ctrl
